// file: pkg/gpde_pkg.sv
// package: register map, field positions and carriers for the port D/E block
package gpde_pkg;

  // ************************************************************
  // register word indices; the byte address is four times the
  // index, and only word-aligned addresses decode to a register
  // ************************************************************
  localparam logic [7:0] GPDE_IDX_PD_DATA   = 8'h03;
  localparam logic [7:0] GPDE_IDX_PE_DATA   = 8'h08;
  localparam logic [7:0] GPDE_IDX_PTC_PUE   = 8'h10;
  localparam logic [7:0] GPDE_IDX_PD_DIR    = 8'h11;
  localparam logic [7:0] GPDE_IDX_PD_PUE    = 8'h12;
  localparam logic [7:0] GPDE_IDX_PE_DIR    = 8'h13;
  localparam logic [7:0] GPDE_IDX_PERIPH    = 8'h14;
  localparam int         GPDE_ADDR_W        = 10;

  // ************************************************************
  // widths and reset values
  // ************************************************************
  localparam int         GPDE_PC_W          = 7;
  localparam int         GPDE_PD_W          = 8;
  localparam int         GPDE_PE_W          = 6;
  localparam logic [7:0] GPDE_DIR_RST       = 8'h00;
  localparam logic [7:0] GPDE_PUE_RST       = 8'h00;
  localparam logic [7:0] GPDE_PERIPH_RST    = 8'h00;
  localparam logic [7:0] GPDE_LATCH_INIT    = 8'h00;

  // ************************************************************
  // pin positions and peripheral control field positions
  // ************************************************************
  localparam int GPDE_PD_SS    = 0;
  localparam int GPDE_PD_MISO  = 1;
  localparam int GPDE_PD_MOSI  = 2;
  localparam int GPDE_PD_SCK   = 3;
  localparam int GPDE_PD_TIM0  = 4;
  localparam int GPDE_PE_TXD   = 0;
  localparam int GPDE_PE_RXD   = 1;
  localparam int GPDE_PER_SPI  = 0;
  localparam int GPDE_PER_MSTR = 1;
  localparam int GPDE_PER_SCI  = 2;
  localparam int GPDE_PER_CLKO = 3;

  // one pin-side carrier per port
  typedef struct packed {
    logic [GPDE_PD_W-1:0] dout;
    logic [GPDE_PD_W-1:0] oe;
    logic [GPDE_PD_W-1:0] pull_en;
  } gpde_pd_pins_t;

  typedef struct packed {
    logic [GPDE_PE_W-1:0] dout;
    logic [GPDE_PE_W-1:0] oe;
  } gpde_pe_pins_t;

  // peripheral pin requests: drive values, spi and timer drive enables, timer own flags
  typedef struct packed {
    logic [3:0] spi_out;
    logic [3:0] spi_oe;
    logic [3:0] tim_own;
    logic [3:0] tim_out;
    logic [3:0] tim_oe;
    logic       clk_out;
    logic       sci_txd;
  } gpde_periph_t;

endpackage

// file: hw/gpde_pin_mux.sv
// per-pin mux: latch/direction versus peripheral drive, pullup gating
`timescale 1ns/1ps
module gpde_pin_mux
  import gpde_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] pue,
  input  wire logic [WIDTH-1:0] own,
  input  wire logic [WIDTH-1:0] per_out,
  input  wire logic [WIDTH-1:0] per_oe,
  input  wire logic [WIDTH-1:0] pin_in,
  output      logic [WIDTH-1:0] dout,
  output      logic [WIDTH-1:0] oe,
  output      logic [WIDTH-1:0] pull_en,
  output      logic [WIDTH-1:0] rdata
);

  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("gpde_pin_mux: WIDTH must be 1..8");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      // peripheral overrides latch and direction for drive
      assign dout[i]   = own[i] ? per_out[i] : latch[i];
      assign oe[i]     = own[i] ? per_oe[i]  : dir[i];
      // pullup only while direction says input and nothing drives
      assign pull_en[i] = pue[i] & ~dir[i] & ~oe[i];
      // direction bit still picks latch or pin on reads
      assign rdata[i]  = dir[i] ? latch[i] : pin_in[i];
    end
  endgenerate

endmodule

// file: hw/gpde_ports.sv
// port D / port E gpio with port C and D pullup enables, APB slave
`timescale 1ns/1ps
// Operation
// - port C pullup enable, seven bits
// - port C pullup only while pin is input
// - port D pullup enable, eight bits
// - port D pullup off when direction is output
// - port D latches, not touched by reset
// - port D direction, 1 output, reset clears
// - port D read: latch if output, else pin
// - latch writes always land, input reads unchanged
// - port D 3..0 SPI, GPIO when SPI off
// - pin 0 GPIO when SPI off or master
// - SPI pins ignore direction, reads still follow it
// - port D 7..4 timer pins via select bits
// - port D pin 0 may carry clock output
// - port E six latches, not touched by reset
// - port E 1 receive, 0 transmit, SCI gated
// - SCI pins ignore direction, reads still follow it
// - port E direction, 1 output, reset clears
// - port E read: latch if output, else pin
module gpde_ports
  import gpde_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [GPDE_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output      logic [31:0]            prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  input  wire logic [GPDE_PD_W-1:0]   pd_pin_in,
  input  wire logic [GPDE_PE_W-1:0]   pe_pin_in,
  input  wire logic [GPDE_PC_W-1:0]   port_c_direction,
  output      gpde_pd_pins_t          pd_pins,
  output      gpde_pe_pins_t          pe_pins,
  output      logic [GPDE_PC_W-1:0]   pc_pullup,
  input  wire gpde_periph_t           periph,
  output      logic                   spi_enable_bit,
  output      logic                   spi_master_select_bit,
  output      logic                   serial_interface_enable_bit,
  output      logic                   clock_out_enable,
  output      logic [3:0]             timer_edge_level_select_a,
  output      logic [3:0]             timer_edge_level_select_b,
  output      logic                   pe_rxd_in,
  output      logic [GPDE_PD_W-1:0]   pd_pin_to_periph
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [GPDE_PD_W-1:0] port_d_data_latch_reg;
  logic [GPDE_PE_W-1:0] port_e_data_latch_reg;
  logic [GPDE_PC_W-1:0] port_c_pullup_enable_reg;
  logic [GPDE_PD_W-1:0] port_d_direction_reg;
  logic [GPDE_PD_W-1:0] port_d_pullup_enable_reg;
  logic [GPDE_PE_W-1:0] port_e_direction_reg;
  logic [7:0]           periph_ctrl_reg;
  logic [7:0]           timer_sel_reg;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire logic [7:0] word_idx   = paddr[GPDE_ADDR_W-1:2];
  wire logic       aligned    = (paddr[1:0] == 2'b00);
  wire logic       access     = psel & penable;
  wire logic       wr_lane0   = access & pwrite & pstrb[0];
  wire logic       wr_lane1   = access & pwrite & pstrb[1];
  wire logic       hit_pddat  = aligned & (word_idx == GPDE_IDX_PD_DATA);
  wire logic       hit_pedat  = aligned & (word_idx == GPDE_IDX_PE_DATA);
  wire logic       hit_pcpue  = aligned & (word_idx == GPDE_IDX_PTC_PUE);
  wire logic       hit_pddir  = aligned & (word_idx == GPDE_IDX_PD_DIR);
  wire logic       hit_pdpue  = aligned & (word_idx == GPDE_IDX_PD_PUE);
  wire logic       hit_pedir  = aligned & (word_idx == GPDE_IDX_PE_DIR);
  wire logic       hit_per    = aligned & (word_idx == GPDE_IDX_PERIPH);
  wire logic       hit_any    = hit_pddat | hit_pedat | hit_pcpue | hit_pddir |
                                hit_pdpue | hit_pedir | hit_per;

  // zero wait states; unmapped or misaligned addresses get pslverr
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // ************************************************************
  // data latches: no reset, write lands whatever the direction
  // ************************************************************
  // reset leaves latch contents as they were
  always_ff @(posedge pclk) begin
    if (wr_lane0 && hit_pddat) begin
      port_d_data_latch_reg <= pwdata[GPDE_PD_W-1:0];
    end
    if (wr_lane0 && hit_pedat) begin
      port_e_data_latch_reg <= pwdata[GPDE_PE_W-1:0];
    end
  end

  // ************************************************************
  // direction, pullup and control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_d_direction_reg     <= GPDE_DIR_RST[GPDE_PD_W-1:0];
      port_e_direction_reg     <= GPDE_DIR_RST[GPDE_PE_W-1:0];
      port_c_pullup_enable_reg <= GPDE_PUE_RST[GPDE_PC_W-1:0];
      port_d_pullup_enable_reg <= GPDE_PUE_RST[GPDE_PD_W-1:0];
      periph_ctrl_reg          <= GPDE_PERIPH_RST;
      timer_sel_reg            <= GPDE_PERIPH_RST;
    end else begin
      if (wr_lane0 && hit_pddir) begin
        port_d_direction_reg <= pwdata[GPDE_PD_W-1:0];
      end
      if (wr_lane0 && hit_pedir) begin
        port_e_direction_reg <= pwdata[GPDE_PE_W-1:0];
      end
      if (wr_lane0 && hit_pcpue) begin
        port_c_pullup_enable_reg <= pwdata[GPDE_PC_W-1:0];
      end
      if (wr_lane0 && hit_pdpue) begin
        port_d_pullup_enable_reg <= pwdata[GPDE_PD_W-1:0];
      end
      if (wr_lane0 && hit_per) begin
        periph_ctrl_reg <= pwdata[7:0];
      end
      if (wr_lane1 && hit_per) begin
        timer_sel_reg <= pwdata[15:8];
      end
    end
  end

  // ************************************************************
  // pin ownership
  // ************************************************************
  assign spi_enable_bit              = periph_ctrl_reg[GPDE_PER_SPI];
  assign spi_master_select_bit       = periph_ctrl_reg[GPDE_PER_MSTR];
  assign serial_interface_enable_bit = periph_ctrl_reg[GPDE_PER_SCI];
  assign clock_out_enable            = periph_ctrl_reg[GPDE_PER_CLKO];
  assign timer_edge_level_select_a   = timer_sel_reg[3:0];
  assign timer_edge_level_select_b   = timer_sel_reg[7:4];

  // timer channel takes its pin when either select bit is set
  wire logic [3:0] tim_sel_own = timer_edge_level_select_a |
                                 timer_edge_level_select_b;

  // slave select is ours only in spi slave mode
  wire logic ss_spi_own = spi_enable_bit & ~spi_master_select_bit;
  // clock output only claims pin 0 when spi does not
  wire logic clk_own    = clock_out_enable & ~ss_spi_own;

  logic [GPDE_PD_W-1:0] pd_own;
  logic [GPDE_PD_W-1:0] pd_per_out;
  logic [GPDE_PD_W-1:0] pd_per_oe;
  logic [GPDE_PE_W-1:0] pe_own;
  logic [GPDE_PE_W-1:0] pe_per_out;
  logic [GPDE_PE_W-1:0] pe_per_oe;

  // spi pins become gpio while spi is off
  assign pd_own[GPDE_PD_SCK]  = spi_enable_bit;
  assign pd_own[GPDE_PD_MOSI] = spi_enable_bit;
  assign pd_own[GPDE_PD_MISO] = spi_enable_bit;
  // pin 0 is plain gpio in spi master mode unless clock out claims it
  assign pd_own[GPDE_PD_SS]   = ss_spi_own | clk_own;
  assign pd_own[7:4]          = tim_sel_own;

  assign pd_per_out[3:1] = periph.spi_out[3:1];
  assign pd_per_oe[3:1]  = periph.spi_oe[3:1];
  // pin 0 drive: clock output, else the spi in slave mode
  assign pd_per_out[GPDE_PD_SS] = clk_own ? periph.clk_out
                                          : periph.spi_out[0];
  assign pd_per_oe[GPDE_PD_SS]  = clk_own | (ss_spi_own & periph.spi_oe[0]);
  assign pd_per_out[7:4] = periph.tim_out;
  assign pd_per_oe[7:4]  = periph.tim_oe & periph.tim_own;

  // serial pins revert to gpio while the interface is off
  assign pe_own[GPDE_PE_TXD]   = serial_interface_enable_bit;
  assign pe_own[GPDE_PE_RXD]   = serial_interface_enable_bit;
  assign pe_own[GPDE_PE_W-1:2] = '0;
  assign pe_per_out = {{(GPDE_PE_W-1){1'b0}}, periph.sci_txd};
  // receive pin is input only; transmit pin always driven when owned
  assign pe_per_oe  = {{(GPDE_PE_W-1){1'b0}}, 1'b1};

  // ************************************************************
  // pin muxes
  // ************************************************************
  logic [GPDE_PD_W-1:0] pd_rdata;
  logic [GPDE_PE_W-1:0] pe_rdata;

  gpde_pin_mux #(.WIDTH(GPDE_PD_W)) u_mux_d (
    .latch   (port_d_data_latch_reg),
    .dir     (port_d_direction_reg),
    .pue     (port_d_pullup_enable_reg),
    .own     (pd_own),
    .per_out (pd_per_out),
    .per_oe  (pd_per_oe),
    .pin_in  (pd_pin_in),
    .dout    (pd_pins.dout),
    .oe      (pd_pins.oe),
    .pull_en (pd_pins.pull_en),
    .rdata   (pd_rdata)
  );

  // port E has no pullups: enables tied off
  gpde_pin_mux #(.WIDTH(GPDE_PE_W)) u_mux_e (
    .latch   (port_e_data_latch_reg),
    .dir     (port_e_direction_reg),
    .pue     ('0),
    .own     (pe_own),
    .per_out (pe_per_out),
    .per_oe  (pe_per_oe),
    .pin_in  (pe_pin_in),
    .dout    (pe_pins.dout),
    .oe      (pe_pins.oe),
    .pull_en (),
    .rdata   (pe_rdata)
  );

  // port C pullup: only while its direction bit says input
  assign pc_pullup = port_c_pullup_enable_reg & ~port_c_direction;

  // live pin levels forwarded to peripherals
  assign pe_rxd_in        = pe_pin_in[GPDE_PE_RXD];
  assign pd_pin_to_periph = pd_pin_in;

  // ************************************************************
  // read mux (registered data output)
  // ************************************************************
  logic [7:0] rd_sel;
  always_comb begin
    rd_sel = 8'h00;
    if (hit_pddat) begin
      rd_sel = pd_rdata;
    end else if (hit_pedat) begin
      rd_sel = {2'b00, pe_rdata};
    end else if (hit_pcpue) begin
      rd_sel = {1'b0, port_c_pullup_enable_reg};
    end else if (hit_pddir) begin
      rd_sel = port_d_direction_reg;
    end else if (hit_pdpue) begin
      rd_sel = port_d_pullup_enable_reg;
    end else if (hit_pedir) begin
      rd_sel = {2'b00, port_e_direction_reg};
    end else if (hit_per) begin
      rd_sel = periph_ctrl_reg;
    end
  end

  // reads are captured in the setup cycle so the access edge sees them;
  // pin levels are thus one cycle old, which is harmless for gpio
  logic [31:0] prdata_reg;
  wire logic [31:0] prdata_next = hit_per ? {16'h0000, timer_sel_reg, rd_sel}
                                          : {24'h000000, rd_sel};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= prdata_next;
    end
  end
  assign prdata = prdata_reg;

endmodule

// file: bench/gpde_ports_asserts.sv
// concurrent checks on the port pins and read path of the port D/E block
`timescale 1ns/1ps
module gpde_ports_asserts
  import gpde_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          prdata,
  input wire logic [GPDE_PC_W-1:0] port_c_direction,
  input wire logic [GPDE_PC_W-1:0] pc_pullup,
  input wire gpde_pd_pins_t        pd_pins,
  input wire gpde_pe_pins_t        pe_pins,
  input wire gpde_periph_t         periph,
  input wire logic                 spi_enable_bit,
  input wire logic                 spi_master_select_bit,
  input wire logic                 serial_interface_enable_bit,
  input wire logic [3:0]           timer_edge_level_select_a,
  input wire logic [3:0]           timer_edge_level_select_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [3:0] tim_sel;
  assign tim_sel = timer_edge_level_select_a | timer_edge_level_select_b;
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_rd_hold:
    assert property (s_rd_setup ##1 s_access |=> $stable(prdata))
    else $error("read data moved right after its access");
  a_pc_pull_gate:
    assert property ((pc_pullup & port_c_direction) == 7'h00)
    else $error("port C pullup left on an output pin");
  a_pd_pull_gate:
    assert property ((pd_pins.pull_en & pd_pins.oe) == 8'h00)
    else $error("port D pullup left on a driven pin");
  a_dir_reset:
    assert property ($rose(presetn) |-> pd_pins.oe == 8'h00 &&
                     pe_pins.oe == 6'h00 && pd_pins.pull_en == 8'h00)
    else $error("pins not all inputs after reset");
  a_rxd_input:
    assert property (serial_interface_enable_bit |-> !pe_pins.oe[1])
    else $error("receive pin driven while serial owns it");
  a_txd_drive:
    assert property (serial_interface_enable_bit |-> pe_pins.oe[0] &&
                     pe_pins.dout[0] == periph.sci_txd)
    else $error("transmit pin not driven by serial");
  a_spi_pins:
    assert property (spi_enable_bit |-> pd_pins.oe[3:1] == periph.spi_oe[3:1]
      && ((pd_pins.dout[3:1] ^ periph.spi_out[3:1]) & pd_pins.oe[3:1]) == 3'h0)
    else $error("spi pins not under spi control");
  a_ss_slave:
    assert property (spi_enable_bit && !spi_master_select_bit |->
                     pd_pins.oe[0] == periph.spi_oe[0])
    else $error("slave select pin not owned in slave mode");
  a_tim_own:
    assert property ((pd_pins.oe[7:4] & tim_sel) ==
                     (periph.tim_oe & periph.tim_own & tim_sel))
    else $error("timer pin enable not from its channel");
endmodule

bind gpde_ports gpde_ports_asserts u_gpde_ports_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .port_c_direction,
  .pc_pullup, .pd_pins, .pe_pins, .periph, .spi_enable_bit,
  .spi_master_select_bit, .serial_interface_enable_bit,
  .timer_edge_level_select_a, .timer_edge_level_select_b
);

// file: bench/gpde_board.sv
// board circuitry seen by the port D and E pins
`timescale 1ns/1ps
module gpde_board
  import gpde_pkg::*;
(
  input  wire logic                 pclk,
  input  wire gpde_pd_pins_t        pd_pins,
  input  wire gpde_pe_pins_t        pe_pins,
  input  wire logic [GPDE_PD_W-1:0] pd_ext,
  input  wire logic                 pd_ext_en,
  input  wire logic [GPDE_PE_W-1:0] pe_ext,
  output      logic [GPDE_PD_W-1:0] pd_pin_in,
  output      logic [GPDE_PE_W-1:0] pe_pin_in
);
  logic [GPDE_PD_W-1:0] float_reg = 8'h5a;
  wire  [GPDE_PD_W-1:0] pd_lvl;
  // a released line without pullup wanders, so no read passes by luck
  assign pd_lvl = pd_ext_en ? pd_ext : (pd_pins.pull_en | float_reg);
  always_ff @(posedge pclk) begin
    float_reg <= ~float_reg;
    pd_pin_in <= (pd_pins.oe & pd_pins.dout) | (~pd_pins.oe & pd_lvl);
    pe_pin_in <= (pe_pins.oe & pe_pins.dout) | (~pe_pins.oe & pe_ext);
  end
endmodule

// file: bench/gpde_ports_tb.sv
// self-checking bench for the port D/E gpio block
`timescale 1ns/1ps
module gpde_ports_tb;
  import gpde_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          pd_ext_en, rxd, clko;
  logic [9:0]    paddr;
  logic [31:0]   pwdata, prdata;
  logic [7:0]    pd_in, pd_ext, vd, md, xd, pd_fwd;
  logic [5:0]    pe_in, pe_ext, ve, me, xe;
  logic [6:0]    pcdir, pc_pullup, c7, d7;
  gpde_pd_pins_t pd_pins;
  gpde_pe_pins_t pe_pins;
  gpde_periph_t  periph, pv;
  logic [32:0]   exp_q[$];
  int            mismatches, samples_checked, i;

  gpde_ports u_gpde_ports (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .pd_pin_in(pd_in),
    .pe_pin_in(pe_in), .port_c_direction(pcdir), .pd_pins, .pe_pins,
    .pc_pullup, .periph, .spi_enable_bit(), .spi_master_select_bit(),
    .serial_interface_enable_bit(), .clock_out_enable(clko),
    .timer_edge_level_select_a(), .timer_edge_level_select_b(),
    .pe_rxd_in(rxd), .pd_pin_to_periph(pd_fwd)
  );
  gpde_board u_gpde_board (
    .pclk, .pd_pins, .pe_pins, .pd_ext, .pd_ext_en, .pe_ext,
    .pd_pin_in(pd_in), .pe_pin_in(pe_in)
  );

  task automatic cmp_rd(input string n, input logic [32:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_pin(input string n, input logic [7:0] e, g);
    cmp_rd(n, {25'h0, e}, {25'h0, g});
  endtask
  // one idle cycle after each transfer keeps every strobe single-driven
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] x, input logic [31:0] d);
    apb(1'b1, {x, 2'b00}, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] x, input logic [31:0] d);
    apb(1'b0, {x, 2'b00}, 32'h0, {1'b0, d});
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1)
      cmp_rd("prdata", exp_q.pop_front(), {pslverr, prdata});
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, pd_ext_en} = 5'h00;
    {paddr, pwdata, pd_ext, pe_ext, pcdir} = 63'h0;
    periph = 22'h0;
    void'($urandom(29978));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_pin("pd_oe", 8'h00, pd_pins.oe);
    for (i = 0; i < 5; i++)
      rd(GPDE_IDX_PTC_PUE + i[7:0], 32'h0);
    xd = 8'($urandom);
    vd = 8'($urandom);
    pd_ext <= xd;
    pd_ext_en <= 1'b1;
    wr(GPDE_IDX_PD_DATA, {24'h0, vd});
    rd(GPDE_IDX_PD_DATA, {24'h0, xd});
    pd_ext_en <= 1'b0;
    wr(GPDE_IDX_PD_PUE, 32'hff);
    cmp_pin("pd_pullup", 8'hff, pd_pins.pull_en);
    rd(GPDE_IDX_PD_DATA, 32'hff);
    md = 8'($urandom);
    wr(GPDE_IDX_PD_DIR, {24'h0, md}); // latch loaded first
    cmp_pin("pd_oe", md, pd_pins.oe);
    cmp_pin("pd_dout", vd & md, pd_pins.dout & md);
    cmp_pin("pd_pullup", ~md, pd_pins.pull_en);
    rd(GPDE_IDX_PD_DATA, {24'h0, vd | ~md});
    for (i = 0; i < 4; i++) begin
      c7 = 7'($urandom);
      d7 = 7'($urandom);
      pcdir <= d7;
      wr(GPDE_IDX_PTC_PUE, {25'h0, c7});
      cmp_pin("pc_pullup", {1'b0, c7 & ~d7}, {1'b0, pc_pullup});
    end
    ve = 6'($urandom);
    me = 6'($urandom);
    xe = 6'($urandom);
    pe_ext <= xe;
    wr(GPDE_IDX_PE_DATA, {26'h0, ve});
    wr(GPDE_IDX_PE_DIR, {26'h0, me});
    cmp_pin("pe_oe", {2'h0, me}, {2'h0, pe_pins.oe});
    rd(GPDE_IDX_PE_DATA, {26'h0, (ve & me) | (xe & ~me)});
    pv = 22'($urandom);
    periph <= pv;
    wr(GPDE_IDX_PERIPH, 32'h1);
    wr(GPDE_IDX_PD_DIR, 32'h0);
    cmp_pin("spi_oe", {4'h0, pv.spi_oe}, {4'h0, pd_pins.oe[3:0]});
    cmp_pin("spi_out", {4'h0, pv.spi_out & pv.spi_oe},
            {4'h0, pd_pins.dout[3:0] & pv.spi_oe});
    wr(GPDE_IDX_PD_DIR, 32'hff);
    rd(GPDE_IDX_PD_DATA, {24'h0, vd});
    wr(GPDE_IDX_PERIPH, 32'h3);
    cmp_pin("ss_gpio", 8'h01, {7'h0, pd_pins.oe[0]});
    wr(GPDE_IDX_PERIPH, 32'hb);
    cmp_pin("clk_out", {7'h0, pv.clk_out}, {7'h0, pd_pins.dout[0]});
    cmp_pin("clk_en", 8'h01, {7'h0, clko});
    // pins toggle at the rising edge, so look at the forward copy between
    @(negedge pclk);
    cmp_pin("pd_fwd", pd_in, pd_fwd);
    @(posedge pclk);
    wr(GPDE_IDX_PERIPH, 32'h4100);
    cmp_pin("tim_oe", {(4'h5 & pv.tim_oe & pv.tim_own) | 4'ha, 4'hf},
            pd_pins.oe);
    wr(GPDE_IDX_PERIPH, 32'h4);
    wr(GPDE_IDX_PE_DIR, 32'h2);
    cmp_pin("sci", {5'h0, pv.sci_txd, 2'b01},
            {5'h0, pe_pins.dout[0], pe_pins.oe[1:0]});
    cmp_pin("rxd_in", {7'h0, xe[1]}, {7'h0, rxd});
    rd(GPDE_IDX_PE_DATA, {26'h0, xe[5:2], ve[1], pv.sci_txd});
    apb(1'b0, 10'h3fc, 32'h0, {1'b1, 32'h0});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(GPDE_IDX_PE_DIR, 32'h0);
    wr(GPDE_IDX_PD_DIR, 32'hff);
    wr(GPDE_IDX_PE_DIR, 32'h3f);
    rd(GPDE_IDX_PD_DATA, {24'h0, vd});
    rd(GPDE_IDX_PE_DATA, {26'h0, ve});
    wrap_up();
  end
endmodule
